// ### logic/tcs_pkg.sv
// Shared constants and types of the timer channel status block
package tcs_pkg;

  localparam int NUM_CH = 6;
  localparam int CNT_W = 16;
  localparam int FLAG_W = 6;
  localparam int STAT_W = 8;
  localparam int NUM_GR = 4;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int WORD_LSB = 2;
  localparam int IDX_W = 3;

  // Register map: one status word per channel
  localparam logic [ADDR_W-1:0] STATUS_BASE = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_STRIDE = 8'h04;

  // Counter wrap limits
  localparam logic [CNT_W-1:0] CNT_TOP = 16'hFFFF;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;

  // Status byte bit positions
  localparam int BIT_DIR = 7;
  localparam int BIT_RSV = 6;
  localparam int BIT_UNF = 5;
  localparam int BIT_OVF = 4;
  localparam int BIT_EVD = 3;
  localparam int BIT_EVC = 2;
  localparam int BIT_EVB = 1;
  localparam int BIT_EVA = 0;

  // Implemented event flags per channel kind
  localparam logic [FLAG_W-1:0] MASK_FOUR_GR = 6'h1F;
  localparam logic [FLAG_W-1:0] MASK_TWO_GR = 6'h33;
  // Channels that carry general registers C and D (channels 0 and 3)
  localparam logic [NUM_CH-1:0] CH_FOUR_GR = 6'h09;

  // Reset and fixed values
  localparam logic DIR_RESET = 1'b1;
  localparam logic RSV_ONE = 1'b1;
  localparam logic [FLAG_W-1:0] FLAGS_RESET = 6'h00;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // What the counter logic of one channel hands to its status register
  typedef struct packed {
    logic [CNT_W-1:0] counter;
    logic count_up;
    logic phase_mode;
    logic [NUM_GR-1:0][CNT_W-1:0] gen_reg;
    logic [NUM_GR-1:0] compare_mode;
    logic [NUM_GR-1:0] capture;
  } tcs_chan_in_t;

  typedef struct packed {
    logic hit;
    logic [IDX_W-1:0] idx;
  } tcs_dec_t;

endpackage

// ### logic/tcs_chan.sv
// One channel's status flags, count direction and interrupt requests
`timescale 1ns/1ns
module tcs_chan #(
  parameter bit FOUR_GR = 1'b0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire tcs_pkg::tcs_chan_in_t chan_in,
  input wire logic rd_arm,
  input wire logic wr_clr,
  input wire logic [tcs_pkg::STAT_W-1:0] wr_byte,
  input wire logic [tcs_pkg::FLAG_W-1:0] irq_enable,
  output logic [tcs_pkg::STAT_W-1:0] status,
  output logic [tcs_pkg::FLAG_W-1:0] irq
);

  typedef struct packed {
    logic [tcs_pkg::CNT_W-1:0] prev_cnt;
    logic count_up;
    logic [tcs_pkg::FLAG_W-1:0] flags;
    logic [tcs_pkg::FLAG_W-1:0] armed;
    logic [tcs_pkg::FLAG_W-1:0] irq;
  } tcs_chan_state_t;

  localparam logic [tcs_pkg::FLAG_W-1:0] MASK =
    FOUR_GR ? tcs_pkg::MASK_FOUR_GR : tcs_pkg::MASK_TWO_GR;

  tcs_chan_state_t s_q;
  tcs_chan_state_t s_d;
  logic ovf;
  logic unf;
  logic [tcs_pkg::NUM_GR-1:0] gr_ev;
  logic [tcs_pkg::FLAG_W-1:0] set_vec;
  logic [tcs_pkg::FLAG_W-1:0] clr_vec;

  assign ovf = (s_q.prev_cnt == tcs_pkg::CNT_TOP) && (chan_in.counter == tcs_pkg::CNT_ZERO);
  assign unf = chan_in.phase_mode && (s_q.prev_cnt == tcs_pkg::CNT_ZERO)
               && (chan_in.counter == tcs_pkg::CNT_TOP);

  // Compare fires on arrival at the value, so a parked counter does not refire after a clear
  genvar g;
  generate
    for (g = 0; g < tcs_pkg::NUM_GR; g++) begin : g_gr
      assign gr_ev[g] = chan_in.compare_mode[g]
        ? ((chan_in.counter == chan_in.gen_reg[g]) && (chan_in.counter != s_q.prev_cnt))
        : chan_in.capture[g];
    end
  endgenerate

  assign set_vec = {unf, ovf, gr_ev} & MASK;
  // Only flags armed by an earlier read as 1 and written 0 are cleared
  assign clr_vec = wr_clr ? (s_q.armed & ~wr_byte[tcs_pkg::FLAG_W-1:0]) : '0;

  always_comb begin
    s_d = s_q;
    s_d.prev_cnt = chan_in.counter;
    s_d.count_up = chan_in.count_up;
    // Set wins over a clear in the same cycle
    s_d.flags = ((s_q.flags & ~clr_vec) | set_vec) & MASK;
    if (rd_arm) begin
      s_d.armed = s_q.flags & MASK;
    end else if (wr_clr) begin
      s_d.armed = '0;
    end
    s_d.irq = s_d.flags & irq_enable;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '{prev_cnt: tcs_pkg::CNT_ZERO, count_up: tcs_pkg::DIR_RESET,
               flags: tcs_pkg::FLAGS_RESET, armed: tcs_pkg::FLAGS_RESET,
               irq: tcs_pkg::FLAGS_RESET};
    end else begin
      s_q <= s_d;
    end
  end

  always_comb begin
    status = '0;
    status[tcs_pkg::FLAG_W-1:0] = s_q.flags;
    status[tcs_pkg::BIT_RSV] = tcs_pkg::RSV_ONE;
    status[tcs_pkg::BIT_DIR] = FOUR_GR ? tcs_pkg::RSV_ONE : s_q.count_up;
  end

  assign irq = s_q.irq;

endmodule

// ### logic/tcs_top.sv
// Six-channel timer status registers behind an AXI4-Lite slave
//
// Function
// - Each of the six channels has its own 8-bit status register showing only its own events.
// - In channels 1, 2, 4 and 5 bit 7 reads 1 while counting up and 0 while down, reset 1.
// - In channels 0 and 3 bit 7 always reads 1 and ignores writes.
// - Bit 6 always reads 1 in every channel and ignores writes.
// - In channels 1, 2, 4, 5 in phase counting, bit 5 sets on a wrap from 0000 to FFFF.
// - In channels 0 and 3 bit 5 always reads 0 and cannot be written.
// - In every channel bit 4 sets when the counter wraps from FFFF to 0000.
// - In channels 0 and 3 bit 3 sets on compare match or capture of register D.
// - In channels 0 and 3 bit 2 sets on compare match or capture of register C.
// - In all channels bit 1 sets on compare match or capture of register B.
// - In all channels bit 0 sets on compare match or capture of register A.
// - In channels 1, 2, 4 and 5 bits 3 and 2 always read 0 and cannot be written.
// - An event flag clears only when written 0 after having been read as 1.
// - Each flag drives its interrupt request only while its enable bit is 1.
`timescale 1ns/1ns
module tcs_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [tcs_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [tcs_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [tcs_pkg::DATA_W/8-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [tcs_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [tcs_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire tcs_pkg::tcs_chan_in_t [tcs_pkg::NUM_CH-1:0] chan_in,
  input wire logic [tcs_pkg::NUM_CH-1:0][tcs_pkg::FLAG_W-1:0] timer_irq_enable,
  output logic [tcs_pkg::NUM_CH-1:0][tcs_pkg::FLAG_W-1:0] chan_irq
);

  typedef struct packed {
    logic aw_got;
    logic [tcs_pkg::ADDR_W-1:0] awaddr;
    logic w_got;
    logic [tcs_pkg::STAT_W-1:0] wbyte;
    logic wlane0;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [tcs_pkg::DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } tcs_bus_state_t;

  // Word index from byte address; low two bits are ignored
  function automatic tcs_pkg::tcs_dec_t tcs_decode(input logic [tcs_pkg::ADDR_W-1:0] addr);
    tcs_pkg::tcs_dec_t d;
    logic [tcs_pkg::ADDR_W-1:0] off;
    off = addr - tcs_pkg::STATUS_BASE;
    d.idx = off[tcs_pkg::WORD_LSB +: tcs_pkg::IDX_W];
    d.hit = (addr >= tcs_pkg::STATUS_BASE)
            && (off < tcs_pkg::ADDR_W'(tcs_pkg::NUM_CH * tcs_pkg::STATUS_STRIDE));
    return d;
  endfunction

  tcs_bus_state_t s_q;
  tcs_bus_state_t s_d;
  tcs_pkg::tcs_dec_t rd_dec;
  tcs_pkg::tcs_dec_t wr_dec;
  logic ar_fire;
  logic wr_fire;
  logic [tcs_pkg::NUM_CH-1:0] rd_arm;
  logic [tcs_pkg::NUM_CH-1:0] wr_clr;
  logic [tcs_pkg::NUM_CH-1:0][tcs_pkg::STAT_W-1:0] chan_status;

  assign rd_dec = tcs_decode(s_axi_araddr);
  assign wr_dec = tcs_decode(s_q.awaddr);
  assign ar_fire = s_axi_arvalid && s_q.arready;
  // A write acts once both halves are held and the previous response has gone
  assign wr_fire = s_q.aw_got && s_q.w_got && !s_q.bvalid;

  genvar c;
  generate
    for (c = 0; c < tcs_pkg::NUM_CH; c++) begin : g_ch
      // The read that returns a flag as 1 is the one that arms its clear
      assign rd_arm[c] = ar_fire && rd_dec.hit
                         && (rd_dec.idx == tcs_pkg::IDX_W'(c));
      assign wr_clr[c] = wr_fire && s_q.wlane0 && wr_dec.hit
                         && (wr_dec.idx == tcs_pkg::IDX_W'(c));
      tcs_chan #(
        .FOUR_GR(tcs_pkg::CH_FOUR_GR[c])
      ) u_chan (
        .aclk(aclk),
        .aresetn(aresetn),
        .chan_in(chan_in[c]),
        .rd_arm(rd_arm[c]),
        .wr_clr(wr_clr[c]),
        .wr_byte(s_q.wbyte),
        .irq_enable(timer_irq_enable[c]),
        .status(chan_status[c]),
        .irq(chan_irq[c])
      );
    end
  endgenerate

  always_comb begin
    s_d = s_q;
    if (s_axi_awvalid && s_q.awready) begin
      s_d.aw_got = 1'b1;
      s_d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_q.wready) begin
      s_d.w_got = 1'b1;
      s_d.wbyte = s_axi_wdata[tcs_pkg::STAT_W-1:0];
      s_d.wlane0 = s_axi_wstrb[0];
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (wr_fire) begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = wr_dec.hit ? tcs_pkg::RESP_OKAY : tcs_pkg::RESP_SLVERR;
    end
    s_d.awready = !s_d.aw_got && !s_d.bvalid;
    s_d.wready = !s_d.w_got && !s_d.bvalid;
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (ar_fire) begin
      s_d.rvalid = 1'b1;
      s_d.rdata = '0;
      s_d.rresp = tcs_pkg::RESP_SLVERR;
      if (rd_dec.hit) begin
        s_d.rdata[tcs_pkg::STAT_W-1:0] = chan_status[rd_dec.idx];
        s_d.rresp = tcs_pkg::RESP_OKAY;
      end
    end
    s_d.arready = !s_d.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready = s_q.awready;
  assign s_axi_wready = s_q.wready;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;

endmodule

// ### bench/tcs_monitor.sv
// Bus and flag checker for the timer status block
`timescale 1ns/1ns
module tcs_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [tcs_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [tcs_pkg::DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire tcs_pkg::tcs_chan_in_t [tcs_pkg::NUM_CH-1:0] chan_in,
  input wire logic [tcs_pkg::NUM_CH-1:0][tcs_pkg::FLAG_W-1:0] timer_irq_enable,
  input wire logic [tcs_pkg::NUM_CH-1:0][tcs_pkg::FLAG_W-1:0] chan_irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_read_single: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("second read taken");
  a_rsv_one: assert property (
    s_axi_rvalid && s_axi_rresp == tcs_pkg::RESP_OKAY |-> s_axi_rdata[6])
    else $error("bit 6 read as 0");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == '0)
    else $error("upper read bytes not 0");
  a_bad_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr >= 8'h18
    |=> s_axi_rresp == tcs_pkg::RESP_SLVERR && s_axi_rdata == '0)
    else $error("unmapped read answered");
  a_irq_gated: assert property (
    (chan_irq & ~timer_irq_enable & ~$past(timer_irq_enable)) == '0)
    else $error("request without enable");
  a_ovf_irq: assert property ($past(chan_in[0].counter) == 16'hFFFF &&
    chan_in[0].counter == 16'h0000 && timer_irq_enable[0][4] |=> chan_irq[0][4])
    else $error("overflow not flagged");
  a_unf_irq: assert property ($past(chan_in[1].counter) == 16'h0000 &&
    chan_in[1].counter == 16'hFFFF && chan_in[1].phase_mode && timer_irq_enable[1][5]
    |=> chan_irq[1][5])
    else $error("underflow not flagged");
  c_bad: cover property (s_axi_rvalid && s_axi_rresp == tcs_pkg::RESP_SLVERR);
  c_ovf: cover property (chan_irq[0][4]);
  c_unf: cover property (chan_irq[1][5]);
endmodule

bind tcs_top tcs_monitor mon (
  .aclk(aclk),
  .aresetn(aresetn),
  .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid),
  .chan_in(chan_in),
  .timer_irq_enable(timer_irq_enable),
  .chan_irq(chan_irq)
);

// ### bench/test_tcs_top.sv
// Self-checking bench for the timer status block
`timescale 1ns/1ns
module test_tcs_top;
  logic aclk = 0;
  logic aresetn = 0;
  logic [7:0] awaddr = 0;
  logic [7:0] araddr = 0;
  logic [31:0] wdata = 0;
  logic awvalid = 0;
  logic wvalid = 0;
  logic arvalid = 0;
  logic [3:0] strb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rd_r, wr_r;
  logic [31:0] rdata, rd_d;
  tcs_pkg::tcs_chan_in_t [5:0] ci = '0;
  logic [5:0][5:0] en = '0;
  logic [5:0][5:0] irq;
  int mismatches = 0;
  int tests_run = 0;
  int cyc = 0;
  always #50 aclk = ~aclk;
  // Both response readies stay high: the bench never stalls an answer
  tcs_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(1'b1), .chan_in(ci), .timer_irq_enable(en), .chan_irq(irq));
  task finish_test;
    $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      mismatches++;
      finish_test;
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task rd(input int c);
    araddr <= 8'(c) * tcs_pkg::STATUS_STRIDE;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd_d = rdata;
    rd_r = rresp;
  endtask
  task wr(input int c, input logic [7:0] d);
    awaddr <= 8'(c) * tcs_pkg::STATUS_STRIDE;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    wr_r = bresp;
  endtask
  task rchk(input int c, input logic [7:0] e);
    rd(c);
    chk({30'h0, rd_r}, {30'h0, tcs_pkg::RESP_OKAY});
    chk(rd_d, {24'h0, e});
  endtask
  task t_reset;
    for (int c = 0; c < 6; c++) rchk(c, 8'hC0);
    ci[0].count_up <= 1'b0;
    ci[1].count_up <= 1'b0;
    wr(1, 8'hFF);
    tick(2);
    rchk(1, 8'h40);
    rchk(0, 8'hC0);
  endtask
  task t_ovf;
    ci[0].counter <= 16'hFFFF;
    tick(1);
    ci[0].counter <= 16'h0000;
    tick(2);
    chk({26'h0, irq[0]}, 32'h10);
    wr(0, 8'h00);
    rchk(0, 8'hD0);
    wr(0, 8'hFF);
    chk({30'h0, wr_r}, {30'h0, tcs_pkg::RESP_OKAY});
    wr(0, 8'h00);
    rchk(0, 8'hD0);
    // A write without the status byte lane neither clears nor disarms
    strb <= 4'h0;
    wr(0, 8'h00);
    strb <= 4'hF;
    chk({26'h0, irq[0]}, 32'h10);
    wr(0, 8'h00);
    rchk(0, 8'hC0);
    chk({26'h0, irq[0]}, 32'h0);
    rchk(3, 8'hC0);
  endtask
  task t_unf;
    ci[1].phase_mode <= 1'b1;
    ci[0].phase_mode <= 1'b1;
    ci[1].counter <= 16'hFFFF;
    ci[0].counter <= 16'hFFFF;
    tick(2);
    chk({26'h0, irq[1]}, 32'h20);
    rchk(1, 8'h60);
    rchk(0, 8'hC0);
    wr(1, 8'h00);
    rchk(1, 8'h40);
  endtask
  task t_evt;
    ci[3].capture <= 4'h8;
    ci[3].gen_reg[2] <= 16'h0005;
    ci[3].compare_mode <= 4'h4;
    ci[2].capture <= 4'hE;
    ci[2].gen_reg[0] <= 16'h0007;
    ci[2].compare_mode <= 4'h1;
    tick(1);
    ci[3].capture <= 4'h0;
    ci[2].capture <= 4'h0;
    ci[3].counter <= 16'h0005;
    ci[2].counter <= 16'h0007;
    tick(2);
    chk({26'h0, irq[2]}, 32'h01);
    chk({26'h0, irq[3]}, 32'h0);
    rchk(3, 8'hCC);
    rchk(2, 8'hC3);
  endtask
  task t_bad;
    rd(6);
    chk({30'h0, rd_r}, {30'h0, tcs_pkg::RESP_SLVERR});
    chk(rd_d, 32'h0);
    wr(6, 8'h00);
    chk({30'h0, wr_r}, {30'h0, tcs_pkg::RESP_SLVERR});
  endtask
  initial begin
    for (int c = 0; c < 6; c++) ci[c].count_up = 1'b1;
    en[0] = 6'h10;
    en[1] = 6'h3F;
    en[2] = 6'h01;
    tick(3);
    aresetn <= 1'b1;
    t_reset;
    t_ovf;
    t_unf;
    t_evt;
    t_bad;
    finish_test;
  end
endmodule
